/* File: core/icol_params.svh */
`ifndef ICOL_PARAMS_SVH
`define ICOL_PARAMS_SVH
// Option word bit positions
`define ICOL_OPT_DATE 0
`define ICOL_OPT_CONSEC 1
`define ICOL_OPT_ADV_LOCK 2
`define ICOL_OPT_PER_MSG 3
`define ICOL_OPT_SW_SEL 4
`define ICOL_OPT_RESTART 5
`define ICOL_OPT_MIRROR 6
`define ICOL_OPT_BARCODE 7
`define ICOL_OPT_RESET 8'h00
// Register word offsets (byte addresses)
`define ICOL_REG_OPTION 8'h00
`define ICOL_REG_MSG 8'h04
`define ICOL_REG_COUNT 8'h08
`define ICOL_REG_CTRL 8'h0C
`define ICOL_REG_STATUS 8'h10
`define ICOL_REG_HEAD 8'h14
// Control register bits (write-one pulses)
`define ICOL_CTRL_ITEM 0
`define ICOL_CTRL_KEY 1
`define ICOL_CTRL_OPT_WR 2
// Status register bits
`define ICOL_ST_CFG 0
`define ICOL_ST_PROMPT 1
`define ICOL_ST_MIRROR 2
`define ICOL_ST_LOWER 3
`define ICOL_COUNT_START 16'h0001
`define ICOL_MSG_RESET 7'h01
`define ICOL_PURGE_CYCLES 16'h03E8
`endif

/* File: core/icol_pkg.sv */
package icol_pkg;
	typedef enum logic [1:0] {
		ICOL_RUN = 2'b00,
		ICOL_CFG_WAIT = 2'b01,
		ICOL_CFG_PROMPT = 2'b10,
		ICOL_CFG_SHOW = 2'b11
	} icol_mode_t;
	typedef struct packed {
		logic [7:0] adr;
		logic [31:0] dat;
		logic [3:0] sel;
		logic we;
		logic cyc;
		logic stb;
	} icol_wb_req_t;
	typedef struct packed {
		logic advance_btn;
		logic purge_btn;
		logic cfg_sw4;
		logic [6:0] rotary;
	} icol_pins_t;
endpackage : icol_pkg

/* File: core/icol_top.sv */
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "icol_params.svh"
module icol_top #(
	parameter int MSG_W = 7,
	parameter int CNT_W = 16,
	parameter int HEADS = 4,
	parameter logic [7:0] HEAD_ID = 8'h41
) (
	input wire logic clk_i, // Board clock
	input wire logic rst_i, // Power-up or reset button
	input wire icol_pkg::icol_wb_req_t wb_i, // Wishbone request
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	input wire icol_pkg::icol_pins_t pins_i, // Board buttons and switches
	output logic [MSG_W-1:0] msg_o, // Active message number
	output logic [CNT_W-1:0] count_o, // Current item count
	output logic mirror_o, // Mirror print enable
	output logic lower_half_o, // Lower half printing allowed
	output logic [HEADS-1:0] purge_o // Purge strobe to every head
);
	import icol_pkg::*;
	localparam int MSGS = 1 << MSG_W;

	// Two-flop synchronisers for pins
	icol_pins_t pins_s1_reg, pins_s2_reg;
	logic adv_prev_reg, purge_prev_reg;
	always_ff @(posedge clk_i) begin
		pins_s1_reg <= pins_i;
		pins_s2_reg <= pins_s1_reg;
		adv_prev_reg <= pins_s2_reg.advance_btn;
		purge_prev_reg <= pins_s2_reg.purge_btn;
	end
	wire adv_edge = pins_s2_reg.advance_btn & ~adv_prev_reg;
	wire purge_edge = pins_s2_reg.purge_btn & ~purge_prev_reg;

	// Option word kept across reset (no reset term: retained storage)
	logic [7:0] opt_nv_reg;
	logic [7:0] opt_reg;
	logic [CNT_W-1:0] single_nv_reg;
	logic [CNT_W-1:0] per_msg_mem [MSGS];
	logic [7:0] head_sel_reg;
	icol_mode_t mode_reg, mode_next;
	logic [MSG_W-1:0] msg_reg, msg_next, kp_msg_reg;
	logic [CNT_W-1:0] count_reg;
	logic boot_reg, sw4_sync_seen_reg;
	logic ack_reg;
	logic [31:0] rdat_reg;
	logic [15:0] purge_cnt_reg;

	// Option decode: each option is its binary weight
	wire opt_consec = opt_reg[`ICOL_OPT_CONSEC];
	wire opt_lock = opt_reg[`ICOL_OPT_ADV_LOCK];
	wire opt_per = opt_reg[`ICOL_OPT_PER_MSG];
	wire opt_sw = opt_reg[`ICOL_OPT_SW_SEL];
	wire opt_restart = opt_reg[`ICOL_OPT_RESTART];
	wire opt_mirror = opt_reg[`ICOL_OPT_MIRROR];
	wire eff_consec = opt_consec & ~opt_per;
	wire eff_restart = opt_restart & ~opt_per;

	// Wishbone decode; only the addressed head's keypad access lands
	wire wb_go = wb_i.cyc & wb_i.stb & ~ack_reg;
	wire wb_wr = wb_go & wb_i.we & wb_i.sel[0];
	wire head_me = (head_sel_reg == HEAD_ID);
	wire wr_opt = wb_wr & (wb_i.adr == `ICOL_REG_OPTION);
	wire wr_msg = wb_wr & (wb_i.adr == `ICOL_REG_MSG) & head_me;
	wire wr_ctrl = wb_wr & (wb_i.adr == `ICOL_REG_CTRL) & head_me;
	wire wr_head = wb_wr & (wb_i.adr == `ICOL_REG_HEAD);
	wire item_pulse = wr_ctrl & wb_i.dat[`ICOL_CTRL_ITEM] & (mode_reg == ICOL_RUN);
	wire key_pulse = wr_ctrl & wb_i.dat[`ICOL_CTRL_KEY];
	wire opt_store = wr_opt & head_me & (mode_reg == ICOL_CFG_PROMPT);
	wire in_cfg = (mode_reg != ICOL_RUN);

	// Message source and advance
	wire [MSG_W-1:0] sel_src = opt_sw ? pins_s2_reg.rotary[MSG_W-1:0] : kp_msg_reg;
	wire adv_ok = adv_edge & ~opt_lock & ~opt_sw;
	always_comb begin
		msg_next = sel_src;
		if (adv_ok) begin
			msg_next = msg_reg + 1'b1;
		end
	end
	wire msg_change = ~boot_reg & ~in_cfg & (msg_next != msg_reg);

	// Option entry sequencer
	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			ICOL_RUN: mode_next = ICOL_RUN;
			ICOL_CFG_WAIT: if (key_pulse) begin
				mode_next = ICOL_CFG_PROMPT;
			end
			ICOL_CFG_PROMPT: if (opt_store) begin
				mode_next = ICOL_CFG_SHOW;
			end
			ICOL_CFG_SHOW: if (key_pulse) begin
				mode_next = ICOL_CFG_PROMPT;
			end
			default: mode_next = ICOL_RUN;
		endcase
	end

	// Retained storage: no reset so values survive reset
	always_ff @(posedge clk_i) begin
		if (opt_store) begin
			opt_nv_reg <= wb_i.dat[7:0];
		end
		// Only a running count is retained; reset and boot values must not overwrite it
		if (~opt_per & ~rst_i & ~boot_reg & ~in_cfg) begin
			single_nv_reg <= count_reg;
		end
		if (opt_per & ~rst_i & ~boot_reg & ~in_cfg) begin
			per_msg_mem[msg_reg] <= count_reg;
		end
	end

	// Power-up sampling of option word and switch 4
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			boot_reg <= 1'b1;
			opt_reg <= `ICOL_OPT_RESET;
			mode_reg <= ICOL_RUN;
			sw4_sync_seen_reg <= 1'b0;
		end else begin
			sw4_sync_seen_reg <= 1'b1;
			if (boot_reg & sw4_sync_seen_reg) begin
				boot_reg <= 1'b0;
				// Options stay inactive during an option entry session
				if (~pins_s2_reg.cfg_sw4) begin
					opt_reg <= opt_nv_reg;
				end
				mode_reg <= pins_s2_reg.cfg_sw4 ? ICOL_CFG_WAIT : ICOL_RUN;
			end else if (~boot_reg) begin
				mode_reg <= mode_next;
			end
		end
	end

	// Item count
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_reg <= `ICOL_COUNT_START;
			msg_reg <= `ICOL_MSG_RESET;
			kp_msg_reg <= `ICOL_MSG_RESET;
			head_sel_reg <= HEAD_ID;
		end else begin
			if (wr_head) begin
				head_sel_reg <= wb_i.dat[7:0];
			end
			// Advance moves the keypad selection too, so it is not undone next cycle
			if (wr_msg) begin
				kp_msg_reg <= wb_i.dat[MSG_W-1:0];
			end else if (adv_ok & ~boot_reg & ~in_cfg) begin
				kp_msg_reg <= msg_reg + 1'b1;
			end
			if (boot_reg & sw4_sync_seen_reg) begin
				msg_reg <= sel_src;
				if (opt_nv_reg[`ICOL_OPT_PER_MSG]) begin
					count_reg <= per_msg_mem[sel_src];
				end else if (opt_nv_reg[`ICOL_OPT_RESTART]) begin
					count_reg <= `ICOL_COUNT_START;
				end else begin
					count_reg <= single_nv_reg;
				end
			end else if (msg_change) begin
				msg_reg <= msg_next;
				if (opt_per) begin
					count_reg <= per_msg_mem[msg_next];
				end else if (~eff_consec) begin
					count_reg <= `ICOL_COUNT_START;
				end else if (item_pulse) begin
					count_reg <= count_reg + 1'b1;
				end
			end else if (item_pulse & ~boot_reg) begin
				count_reg <= count_reg + 1'b1;
			end
		end
	end

	// Purge: all heads fire together for 1000 cycles, restarted by each new press
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			purge_cnt_reg <= 16'h0000;
		end else if (purge_edge) begin
			purge_cnt_reg <= `ICOL_PURGE_CYCLES;
		end else if (purge_cnt_reg != 16'h0000) begin
			purge_cnt_reg <= purge_cnt_reg - 16'h0001;
		end
	end

	// Read mux
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (wb_i.adr)
			`ICOL_REG_OPTION: rd_mux = {24'h000000, in_cfg ? opt_nv_reg : opt_reg};
			`ICOL_REG_MSG: rd_mux = {{(32-MSG_W){1'b0}}, msg_reg};
			`ICOL_REG_COUNT: rd_mux = {{(32-CNT_W){1'b0}}, count_reg};
			`ICOL_REG_STATUS: rd_mux = {28'h0000000, opt_mirror, opt_mirror,
				mode_reg == ICOL_CFG_PROMPT, in_cfg};
			`ICOL_REG_HEAD: rd_mux = {24'h000000, head_sel_reg};
			default: rd_mux = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= wb_go;
			rdat_reg <= rd_mux;
		end
	end

	// Registered outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			msg_o <= `ICOL_MSG_RESET;
			count_o <= `ICOL_COUNT_START;
			mirror_o <= 1'b0;
			lower_half_o <= 1'b0;
			purge_o <= '0;
		end else begin
			msg_o <= msg_reg;
			count_o <= count_reg;
			mirror_o <= opt_mirror;
			lower_half_o <= opt_mirror;
			purge_o <= {HEADS{purge_cnt_reg != 16'h0000}};
		end
	end
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

	lock_adv_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(opt_lock & ~opt_sw & ~in_cfg & ~boot_reg & $stable(kp_msg_reg))
		|=> $stable(msg_reg)) else $error("Message moved while advance locked");
	sw_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(opt_sw & ~in_cfg & ~boot_reg) |=> msg_reg == $past(sel_src))
		else $error("Message not from rotary switches");
	consec_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(msg_change & eff_consec & ~item_pulse) |=> $stable(count_reg))
		else $error("Consecutive count disturbed by change");
	restart_chg_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(msg_change & ~opt_per & ~opt_consec) |=> count_reg == 16'h0001)
		else $error("Count not restarted on change");
	per_msg_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(msg_change & opt_per) |=> count_reg == per_msg_mem[msg_reg])
		else $error("Per-message count not restored");
	sequence purge_press_s;
		purge_edge;
	endsequence
	purge_all_a: assert property (@(posedge clk_i) disable iff (rst_i)
		purge_press_s |=> ##1 (&purge_o)) else $error("Not all heads purged");
	mirror_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
		##1 (mirror_o == $past(opt_mirror)) and (lower_half_o == mirror_o))
		else $error("Mirror output wrong");
	opt_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(~boot_reg & $past(~boot_reg)) |-> $stable(opt_reg))
		else $error("Option word changed outside power-up");
	cfg_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
		opt_store |=> (opt_nv_reg == $past(wb_i.dat[7:0])) && mode_reg == ICOL_CFG_SHOW)
		else $error("Option entry not stored");
	per_dis_a: assert property (@(posedge clk_i) disable iff (rst_i)
		opt_per |-> ~eff_consec & ~eff_restart) else $error("Options not overridden");
endmodule : icol_top
`default_nettype wire

/* File: sim/icol_panel_model.sv */
`timescale 1ns/1ns
`default_nettype none
module icol_panel_model
	import icol_pkg::*;
(
	input wire logic clk_i, // Board clock
	input wire logic adv_i, // Operator taps advance
	input wire logic purge_i, // Operator taps purge
	input wire logic cfg_i, // Switch 4 position
	input wire logic [6:0] rotary_i, // Selector setting
	output var icol_pkg::icol_pins_t pins_o // Board pin levels
);
	logic [3:0] adv_reg = 4'h0;
	logic [3:0] prg_reg = 4'h0;
	// Presses held long enough to pass the pin synchronisers
	always @(posedge clk_i) begin
		adv_reg <= adv_i ? 4'h8 : (adv_reg != 4'h0 ? adv_reg - 4'h1 : 4'h0);
		prg_reg <= purge_i ? 4'h8 : (prg_reg != 4'h0 ? prg_reg - 4'h1 : 4'h0);
	end
	assign pins_o.advance_btn = adv_reg != 4'h0;
	assign pins_o.purge_btn = prg_reg != 4'h0;
	assign pins_o.cfg_sw4 = cfg_i;
	assign pins_o.rotary = rotary_i;
endmodule : icol_panel_model
`default_nettype wire

/* File: sim/tb_item_count_option_logic.sv */
`timescale 1ns/1ns
`default_nettype none
`include "icol_params.svh"
module tb_item_count_option_logic;
	import icol_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	icol_wb_req_t wb = '0;
	icol_pins_t pins;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [6:0] msg_o;
	logic [15:0] count_o;
	logic mirror_o;
	logic lower_half_o;
	logic [3:0] purge_o;
	logic adv = 1'b0;
	logic prg = 1'b0;
	logic cfg = 1'b0;
	logic [6:0] rot = 7'h01;
	logic [31:0] rd;
	int n_fail = 0;
	int num_checks = 0;
	int cyc_n = 0;
	always #5 clk_i = ~clk_i;
	icol_top u_icol_top (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .pins_i(pins), .msg_o(msg_o), .count_o(count_o),
		.mirror_o(mirror_o), .lower_half_o(lower_half_o), .purge_o(purge_o));
	icol_panel_model u_icol_panel_model (.clk_i(clk_i), .adv_i(adv), .purge_i(prg),
		.cfg_i(cfg), .rotary_i(rot), .pins_o(pins));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task tally_and_finish;
		$display("checks=%0d errors=%0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb <= '{adr: a, dat: d, sel: 4'hF, we: w, cyc: 1'b1, stb: 1'b1};
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && n < 40) begin
			@(posedge clk_i);
			n++;
		end
		if (n == 40) begin
			n_fail++;
			tally_and_finish;
		end
		rd = wb_dat_o;
		wb.cyc <= 1'b0;
		wb.stb <= 1'b0;
		@(posedge clk_i);
	endtask : xfer
	task settle;
		repeat (6) @(posedge clk_i);
	endtask : settle
	task power_up(input logic sw);
		cfg <= sw;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		xfer(1'b1, `ICOL_REG_HEAD, 32'h41);
	endtask : power_up
	// Option entry session, then a normal power-up
	task prog(input logic [7:0] v);
		power_up(1'b1);
		xfer(1'b1, `ICOL_REG_CTRL, 32'h2);
		xfer(1'b0, `ICOL_REG_STATUS, 32'h0);
		chk(rd & 32'h3, 32'h3);
		xfer(1'b1, `ICOL_REG_OPTION, {24'h0, v});
		xfer(1'b0, `ICOL_REG_OPTION, 32'h0);
		chk(rd, {24'h0, v});
		xfer(1'b0, `ICOL_REG_STATUS, 32'h0);
		chk(rd & 32'h3, 32'h1);
		power_up(1'b0);
	endtask : prog
	task items(input int k);
		repeat (k) xfer(1'b1, `ICOL_REG_CTRL, 32'h1);
	endtask : items
	task tap(input logic p);
		if (p) prg <= 1'b1;
		else adv <= 1'b1;
		@(posedge clk_i);
		prg <= 1'b0;
		adv <= 1'b0;
		repeat (12) @(posedge clk_i);
	endtask : tap
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			n_fail++;
			tally_and_finish;
		end
	end
	initial begin
		prog(8'h62);
		chk(32'(count_o), 32'h1);
		chk(32'({mirror_o, lower_half_o}), 32'h3);
		items(3);
		xfer(1'b1, `ICOL_REG_MSG, 32'h5);
		settle;
		chk(32'(count_o), 32'h4);
		xfer(1'b0, `ICOL_REG_COUNT, 32'h0);
		chk(rd, 32'h4);
		tap(1'b0);
		chk(32'(msg_o), 32'h6);
		xfer(1'b1, `ICOL_REG_HEAD, 32'h42);
		xfer(1'b1, `ICOL_REG_MSG, 32'h9);
		settle;
		chk(32'(msg_o), 32'h6);
		tap(1'b1);
		chk(32'(purge_o), 32'hF);
		power_up(1'b0);
		chk(32'(count_o), 32'h1);
		prog(8'h20);
		items(2);
		xfer(1'b1, `ICOL_REG_MSG, 32'h2);
		settle;
		chk(32'(count_o), 32'h1);
		prog(8'h00);
		chk(32'({mirror_o, lower_half_o}), 32'h0);
		xfer(1'b1, `ICOL_REG_MSG, 32'h3);
		settle;
		chk(32'(count_o), 32'h1);
		items(2);
		power_up(1'b0);
		chk(32'(count_o), 32'h3);
		prog(8'h34);
		rot <= 7'h09;
		settle;
		chk(32'(msg_o), 32'h9);
		tap(1'b0);
		chk(32'(msg_o), 32'h9);
		xfer(1'b1, `ICOL_REG_MSG, 32'h3);
		settle;
		chk(32'(msg_o), 32'h9);
		tally_and_finish;
	end
endmodule : tb_item_count_option_logic
`default_nettype wire
